/* File: core_clock_and_power_mode_ctrl.sv */
// Clock source, divider, oscillator enable and Idle/Stop power-mode controller.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "core_clock_params.svh"

module core_clock_and_power_mode_ctrl (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_osc_tick,
  input  wire logic       irq_wake,
  output logic            core_clk_en,
  output logic            cpu_clk_en,
  output logic            periph_clk_en,
  output logic            int_osc_run,
  output logic      [7:0] osc_trim,
  output logic      [15:0] reset_fetch_addr,
  output logic            irq
);
  core_clock_pkg::reg_req_s     req;
  core_clock_pkg::power_state_e pstate_r;
  logic [5:0]               spare_software_flags_r;
  logic [1:0]               osc_divide_select_r;
  logic                     int_osc_enable_r;
  logic                     clock_source_select_r;
  logic                     osc_freq_ready_flag_r;
  logic [7:0]               settle_cnt_r;
  logic [7:0]               oscillator_trim_r;
  logic [1:0]               irq_stat_r;
  logic [1:0]               irq_mask_r;
  logic                     ready_prev_r;
  logic                     div_tick;
  logic                     stopped;
  logic                     wr_pmc;
  logic                     wr_osc;
  logic                     wr_stat;
  logic [1:0]               ev;

  localparam logic [7:0] SETTLE_CNT = 8'(`SETTLE_CYCLES);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign req     = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign wr_pmc  = req.wr && hit(req.addr, `PMC_ADDR);
  assign wr_osc  = req.wr && hit(req.addr, `OSC_CTRL_ADDR);
  assign wr_stat = req.wr && hit(req.addr, `IRQ_STAT_ADDR);
  // Stop halts the clocks and the internal oscillator and freezes control, trim and flag registers, not the irq mask or status.
  assign stopped = (pstate_r == core_clock_pkg::PM_STOP);

  // Power state: the stop and idle bits are pulses, never stored as bits.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pstate_r <= core_clock_pkg::PM_RUN;
    end else begin
      case (pstate_r)
        core_clock_pkg::PM_RUN: begin
          if (wr_pmc && req.wdata[`BIT_STOP]) begin
            pstate_r <= core_clock_pkg::PM_STOP;
          end else if (wr_pmc && req.wdata[`BIT_IDLE]) begin
            pstate_r <= core_clock_pkg::PM_IDLE;
          end
        end
        core_clock_pkg::PM_IDLE: begin
          if (irq_wake) begin
            pstate_r <= core_clock_pkg::PM_RUN;
          end
        end
        // Only sys_rst (pin or lost-clock detector reset) leaves this state.
        core_clock_pkg::PM_STOP: pstate_r <= core_clock_pkg::PM_STOP;
        default:             pstate_r <= core_clock_pkg::PM_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      spare_software_flags_r <= 6'h00;
    end else if (wr_pmc && !stopped) begin
      spare_software_flags_r <= req.wdata[7:2];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_divide_select_r   <= 2'(`OSC_CTRL_RESET >> `BIT_DIV_LO);
      int_osc_enable_r      <= 1'(`OSC_CTRL_RESET >> `BIT_ENABLE);
      clock_source_select_r <= 1'(`OSC_CTRL_RESET >> `BIT_SOURCE);
    end else if (wr_osc && !stopped) begin
      // Bits 7..5 and the ready bit are dropped here.
      osc_divide_select_r   <= req.wdata[`BIT_DIV_LO +: 2];
      int_osc_enable_r      <= req.wdata[`BIT_ENABLE];
      clock_source_select_r <= req.wdata[`BIT_SOURCE];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oscillator_trim_r <= `OSC_TRIM_RESET;
    end else if (req.wr && hit(req.addr, `OSC_TRIM_ADDR) && !stopped) begin
      oscillator_trim_r <= req.wdata;
    end
  end

  assign int_osc_run = int_osc_enable_r && !stopped;
  assign osc_trim    = oscillator_trim_r;

  // Settling model: a retrim also restarts it since the frequency moves.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_cnt_r          <= 8'h00;
      osc_freq_ready_flag_r <= 1'(`OSC_CTRL_RESET >> `BIT_READY);
    end else if (!int_osc_run) begin
      settle_cnt_r          <= 8'h00;
      osc_freq_ready_flag_r <= 1'b0;
    end else if (req.wr && hit(req.addr, `OSC_TRIM_ADDR)) begin
      settle_cnt_r          <= 8'h00;
      osc_freq_ready_flag_r <= 1'b0;
    end else if (!osc_freq_ready_flag_r) begin
      if (settle_cnt_r == SETTLE_CNT - 8'h01) begin
        osc_freq_ready_flag_r <= 1'b1;
      end
      settle_cnt_r <= settle_cnt_r + 8'h01;
    end
  end

  osc_divider u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (int_osc_run),
    .sel     (core_clock_pkg::div_sel_e'(osc_divide_select_r)),
    .tick    (div_tick)
  );

  // The external path is passed through; switching source is glitch-free
  // because both sources are enables on the one fabric clock.
  always_comb begin
    if (stopped) begin
      core_clk_en = 1'b0;
    end else if (clock_source_select_r) begin
      core_clk_en = ext_osc_tick;
    end else begin
      core_clk_en = div_tick;
    end
  end

  assign cpu_clk_en    = core_clk_en && (pstate_r == core_clock_pkg::PM_RUN);
  assign periph_clk_en = core_clk_en;
  assign reset_fetch_addr = 16'h0000;

  // Events: oscillator became ready, oscillator lost ready.
  // The history starts at the ready flag's reset level, so reset alone logs no event.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_prev_r <= 1'(`OSC_CTRL_RESET >> `BIT_READY);
    end else begin
      ready_prev_r <= osc_freq_ready_flag_r;
    end
  end

  assign ev = {ready_prev_r && !osc_freq_ready_flag_r, !ready_prev_r && osc_freq_ready_flag_r};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_r <= 2'h0;
    end else begin
      // A new event wins over a write-one clear in the same cycle.
      irq_stat_r <= (irq_stat_r & ~(wr_stat ? req.wdata[1:0] : 2'h0)) | ev;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_r <= 2'h0;
    end else if (req.wr && hit(req.addr, `IRQ_MASK_ADDR)) begin
      irq_mask_r <= req.wdata[1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        `PMC_ADDR:      reg_rdata <= {spare_software_flags_r, 2'h0};
        `OSC_CTRL_ADDR: reg_rdata <= {3'h0, osc_freq_ready_flag_r, clock_source_select_r,
                                      int_osc_enable_r, osc_divide_select_r};
        `OSC_TRIM_ADDR: reg_rdata <= oscillator_trim_r;
        `IRQ_STAT_ADDR: reg_rdata <= {6'h00, irq_stat_r};
        `IRQ_MASK_ADDR: reg_rdata <= {6'h00, irq_mask_r};
        default:        reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks on power state, clock enables, the ready flag and register reads.
  // All are off during reset, because every register is forced there anyway.

  a_stop_entry: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_pmc && reg_wdata[`BIT_STOP] && pstate_r == core_clock_pkg::PM_RUN) |=> stopped)
    else $error("stop write did not enter stop");

  a_idle_entry: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_pmc && reg_wdata[`BIT_IDLE] && !reg_wdata[`BIT_STOP]
     && pstate_r == core_clock_pkg::PM_RUN) |=> (pstate_r == core_clock_pkg::PM_IDLE))
    else $error("idle write did not enter idle");

  a_stop_stays: assert property (@(posedge clk) disable iff (sys_rst)
    stopped |=> stopped)
    else $error("stop left without reset");

  a_stop_halts: assert property (@(posedge clk) disable iff (sys_rst)
    stopped |-> (!core_clk_en && !int_osc_run))
    else $error("clock running in stop");

  a_trim_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    stopped |=> $stable(oscillator_trim_r))
    else $error("trim changed in stop");

  a_idle_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (pstate_r == core_clock_pkg::PM_IDLE) |-> (!cpu_clk_en && periph_clk_en == core_clk_en))
    else $error("idle gating wrong");

  a_cpu_run: assert property (@(posedge clk) disable iff (sys_rst)
    (pstate_r == core_clock_pkg::PM_RUN) |-> (cpu_clk_en == core_clk_en))
    else $error("cpu clock missing in run");

  a_pmc_read: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `PMC_ADDR) |=> (reg_rdata[1:0] == 2'h0))
    else $error("idle or stop bit read nonzero");

  a_flags_write: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_pmc && !stopped) |=> (spare_software_flags_r == $past(reg_wdata[7:2])))
    else $error("software flags not stored");

  a_osc_upper: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `OSC_CTRL_ADDR) |=> (reg_rdata[7:5] == 3'h0))
    else $error("unused oscillator bits nonzero");

  a_ready_read: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `OSC_CTRL_ADDR)
    |=> (reg_rdata[`BIT_READY] == $past(osc_freq_ready_flag_r)))
    else $error("ready bit read wrong");

  a_ready_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_osc && reg_wdata[`BIT_ENABLE] && int_osc_run && osc_freq_ready_flag_r)
    |=> osc_freq_ready_flag_r)
    else $error("control write moved ready");

  a_ready_off: assert property (@(posedge clk) disable iff (sys_rst)
    !int_osc_run |=> !osc_freq_ready_flag_r)
    else $error("ready while oscillator off");

  a_ready_settle: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(int_osc_run) |-> !osc_freq_ready_flag_r [*8])
    else $error("ready rose too early");

  // A new select may legally cut the current period short, so only a steady one is checked.
  a_div_eight: assert property (@(posedge clk) disable iff (sys_rst)
    (div_tick && !clock_source_select_r && osc_divide_select_r == 2'h0 && !wr_osc
     && int_osc_run) |=> (!div_tick || osc_divide_select_r != 2'h0) [*7])
    else $error("divide by eight wrong");

  a_osc_off_tick: assert property (@(posedge clk) disable iff (sys_rst)
    !int_osc_run |=> !div_tick)
    else $error("divider ticks with oscillator off");

  a_int_source: assert property (@(posedge clk) disable iff (sys_rst)
    (!clock_source_select_r && !stopped) |-> (core_clk_en == div_tick))
    else $error("internal source not used");

  a_ext_source: assert property (@(posedge clk) disable iff (sys_rst)
    (clock_source_select_r && !stopped) |-> (core_clk_en == ext_osc_tick))
    else $error("external source not used");

  // Main scenarios that the bench is expected to reach.
  c_stop: cover property (@(posedge clk) disable iff (sys_rst) $rose(stopped));
  c_idle_wake: cover property (@(posedge clk) disable iff (sys_rst)
    pstate_r == core_clock_pkg::PM_IDLE ##1 pstate_r == core_clock_pkg::PM_RUN);
  c_ready: cover property (@(posedge clk) disable iff (sys_rst) $rose(osc_freq_ready_flag_r));
  c_ext_source: cover property (@(posedge clk) disable iff (sys_rst)
    clock_source_select_r && core_clk_en);
  c_stat_clear: cover property (@(posedge clk) disable iff (sys_rst)
    wr_stat && (irq_stat_r != 2'h0));
endmodule : core_clock_and_power_mode_ctrl

/* File: core_clock_params.svh */
// Register offsets, field positions, reset values and timing counts of the clock controller.
`ifndef CORE_CLOCK_PARAMS_SVH
`define CORE_CLOCK_PARAMS_SVH
`define PMC_ADDR        8'h87
`define OSC_CTRL_ADDR   8'hB2
`define OSC_TRIM_ADDR   8'hB3
`define IRQ_STAT_ADDR   8'hC8
`define IRQ_MASK_ADDR   8'hC9
`define PMC_RESET       8'h00
`define OSC_CTRL_RESET  8'h14
`define OSC_TRIM_RESET  8'h40
`define BIT_IDLE        0
`define BIT_STOP        1
`define BIT_DIV_LO      0
`define BIT_ENABLE      2
`define BIT_SOURCE      3
`define BIT_READY       4
`define SETTLE_NS       2000
`define CLK_PERIOD_NS   25
`define SETTLE_CYCLES   ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: core_clock_pkg.sv */
// Types shared by the clock and power-mode controller.
package core_clock_pkg;
  typedef enum logic [1:0] {
    DIV_BY_8,
    DIV_BY_4,
    DIV_BY_2,
    DIV_BY_1
  } div_sel_e;
  typedef enum logic [1:0] {
    PM_RUN,
    PM_IDLE,
    PM_STOP
  } power_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;
endpackage : core_clock_pkg

/* File: osc_divider.sv */
// Internal oscillator post-divider that forms a clock-enable pulse train.
`timescale 1ns/1ps
module osc_divider (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              run,
  input  wire core_clock_pkg::div_sel_e sel,
  output logic                   tick
);
  logic [2:0] cnt_r;
  logic [2:0] limit;

  always_comb begin
    case (sel)
      core_clock_pkg::DIV_BY_8: limit = 3'h7;
      core_clock_pkg::DIV_BY_4: limit = 3'h3;
      core_clock_pkg::DIV_BY_2: limit = 3'h1;
      default:              limit = 3'h0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 3'h0;
    end else if (!run || cnt_r >= limit) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (cnt_r >= limit);
    end
  end
endmodule : osc_divider

/* File: tb_core_clock_and_power_mode_ctrl.sv */
// Self-checking bench for the clock source and power-mode controller.
`timescale 1ns/1ps
`include "core_clock_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module tb_core_clock_and_power_mode_ctrl;
  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_s;

  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        ext_osc_tick = 1'b0;
  logic        irq_wake = 1'b0;
  logic        core_clk_en;
  logic        cpu_clk_en;
  logic        periph_clk_en;
  logic        int_osc_run;
  logic [7:0]  osc_trim;
  logic [15:0] reset_fetch_addr;
  logic        irq;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          cc, cp, pp;
  logic [7:0]  rv;
  row_s        rows [11];

  core_clock_and_power_mode_ctrl core_clock_and_power_mode_ctrl_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_osc_tick(ext_osc_tick), .irq_wake(irq_wake), .core_clk_en(core_clk_en),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .int_osc_run(int_osc_run), .osc_trim(osc_trim),
    .reset_fetch_addr(reset_fetch_addr), .irq(irq)
  );

  always #12.5 clk = ~clk;

  task end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // A hang in any wait is cut here; the full run needs under 1500 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task cnt(input int n);
    cc = 0;
    cp = 0;
    pp = 0;
    repeat (n) begin
      @(negedge clk);
      cc += (core_clk_en === 1'b1);
      cp += (cpu_clk_en === 1'b1);
      pp += (periph_clk_en === 1'b1);
    end
  endtask : cnt

  initial begin
    rows = '{'{0, 8'h87, 8'h00, 8'h00}, '{0, 8'hB2, 8'h00, 8'h14}, '{0, 8'hB3, 8'h00, 8'h40},
             '{0, 8'hC8, 8'h00, 8'h00}, '{1, 8'h55, 8'hAA, 8'h00}, '{1, 8'h87, 8'hFC, 8'hFC},
             '{1, 8'hC9, 8'h03, 8'h03}, '{1, 8'hB3, 8'h5A, 8'h5A}, '{0, 8'hC8, 8'h00, 8'h02},
             '{1, 8'hB2, 8'hFF, 8'h0F}, '{1, 8'hC8, 8'h02, 8'h00}};
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      `CHK("register", rows[i].e, rv)
    end
    `CHK("irq cleared", 1'b0, irq)
    `CHK("trim output", 8'h5A, osc_trim)
    repeat (`SETTLE_CYCLES + 10) @(posedge clk);
    rd(8'hB2, rv);
    `CHK("ready back", 8'h1F, rv)
    rd(8'hC8, rv);
    `CHK("rose status", 8'h01, rv)
    #1 `CHK("irq raised", 1'b1, irq)
    wr(8'hC9, 8'h02);
    #1 `CHK("irq masked", 1'b0, irq)
    wr(8'hC8, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(8'hB2, 8'h04 | 8'(k));
      repeat (4) @(posedge clk);
      cnt(64);
      `CHK("divider", 64 >> (3 - k), cc)
    end
    wr(8'hB2, 8'h0C);
    cc = 0;
    for (int i = 0; i < 70; i++) begin
      @(posedge clk);
      ext_osc_tick <= (i < 60 && i % 3 == 0);
      @(negedge clk);
      cc += (core_clk_en === 1'b1);
    end
    `CHK("external source", 20, cc)
    // Software leaves the external source for a nonvolatile write, then returns.
    wr(8'hB2, 8'h04);
    ext_osc_tick <= 1'b1;
    cnt(64);
    `CHK("internal for flash", 8, cc)
    wr(8'hB2, 8'h0C);
    cnt(8);
    `CHK("back to external", 8, cc)
    @(posedge clk);
    ext_osc_tick <= 1'b0;
    wr(8'hB2, 8'h00);
    #1 `CHK("osc off", 1'b0, int_osc_run)
    rd(8'hB2, rv);
    `CHK("ready off", 8'h00, rv)
    cnt(32);
    `CHK("no clock", 0, cc)
    wr(8'hB2, 8'h04);
    repeat (40) @(posedge clk);
    rd(8'hB2, rv);
    `CHK("not settled", 8'h04, rv)
    repeat (`SETTLE_CYCLES) @(posedge clk);
    rd(8'hB2, rv);
    `CHK("settled", 8'h14, rv)
    wr(8'h87, 8'hFD);
    rd(8'h87, rv);
    `CHK("idle reads", 8'hFC, rv)
    cnt(32);
    `CHK("cpu gated", 0, cp)
    `CHK("periph runs", 4, pp)
    @(posedge clk);
    irq_wake <= 1'b1;
    @(posedge clk);
    irq_wake <= 1'b0;
    cnt(32);
    `CHK("cpu woke", 4, cp)
    wr(8'h87, 8'h02);
    #1 `CHK("stop osc", 1'b0, int_osc_run)
    @(posedge clk);
    irq_wake <= 1'b1;
    cnt(32);
    `CHK("stop clocks", 0, cc + cp + pp)
    wr(8'hB3, 8'h11);
    #1 `CHK("trim frozen", 8'h5A, osc_trim)
    // A wake request still high must not matter: only reset ends Stop.
    @(posedge clk);
    irq_wake <= 1'b0;
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'hB2, rv);
    `CHK("after reset", 8'h14, rv)
    `CHK("fetch addr", 16'h0000, reset_fetch_addr)
    cnt(16);
    `CHK("running again", 2, cp)
    end_sim();
  end
endmodule : tb_core_clock_and_power_mode_ctrl
